// *** rtl/rtc_ctrl_consts.vh ***
// Register indices, field positions, reset values and timing constants of the RTC control block.
`ifndef RTC_CTRL_CONSTS_VH
`define RTC_CTRL_CONSTS_VH

// ==========================================================
// Register indices (byte address is four times the index)
// ==========================================================
`define IDX_EVENT_FLAG_ENABLE_CONTROL 6'h01
`define IDX_POWER_BATTERY_CONTROL 6'h02
`define IDX_CLOCK_OUTPUT_CONTROL 6'h0f

// ==========================================================
// Event flag and enable register fields
// ==========================================================
`define BIT_MINUTE_SECOND_FLAG 7
`define BIT_WATCHDOG_EVENT_FLAG 6
`define BIT_TIMESTAMP_GROUND_FLAG 5
`define BIT_ALARM_FLAG 4
`define BIT_COUNTDOWN_FLAG 3
`define BIT_TIMESTAMP_IRQ_ENABLE 2
`define BIT_ALARM_IRQ_ENABLE 1
`define BIT_COUNTDOWN_IRQ_ENABLE 0

// ==========================================================
// Power and battery register fields
// ==========================================================
`define POS_POWER_MANAGEMENT_SELECT 5
`define BIT_SWITCHOVER_CAPTURE_ENABLE 4
`define BIT_BATTERY_SWITCHOVER_FLAG 3
`define BIT_BATTERY_LOW_FLAG 2
`define BIT_SWITCHOVER_IRQ_ENABLE 1
`define BIT_BATTERY_LOW_IRQ_ENABLE 0

// ==========================================================
// Clock output register fields, their reset values and the power selector reset value
// ==========================================================
`define POS_TEMP_PERIOD_SELECT 6
`define POS_OUTPUT_FREQ_SELECT 0
`define RESET_TEMP_PERIOD_SELECT 2'h0
`define RESET_OUTPUT_FREQ_SELECT 3'h0
`define RESET_POWER_MANAGEMENT_SELECT 3'h0
`define FREQ_SELECT_ONE_HZ 3'h6
`define FREQ_SELECT_DISABLED 3'h7

// ==========================================================
// Timing
// ==========================================================
`define TEMP_PERIOD_4_MIN_SEC 8'd240
`define TEMP_PERIOD_2_MIN_SEC 8'd120
`define TEMP_PERIOD_1_MIN_SEC 8'd60
`define TEMP_PERIOD_30_SEC 8'd30
`endif

// *** rtl/rtc_status_and_clock_output_ctrl.v ***
// RTC event flags, power and battery control, temperature timing and square-wave output.
`timescale 1ns/10ps
`include "rtc_ctrl_consts.vh"
`default_nettype none

module rtc_status_and_clock_output_ctrl #(
  parameter CLK_HZ = 50000000,
  parameter OSC_HZ = 32768
) (
  input wire clk,
  input wire arst_n,
  input wire [7:0] address,
  input wire read,
  input wire write,
  input wire [3:0] byteenable,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output reg waitrequest,
  input wire minute_second_event,
  input wire watchdog_event,
  input wire timestamp_input_pin,
  input wire alarm_event,
  input wire countdown_event,
  input wire switchover_event,
  input wire battery_low,
  output reg irq,
  output reg switchover_capture,
  output reg [2:0] power_management_select,
  output reg temp_measure_start,
  output reg square_wave_out_pin,
  output reg square_wave_out_pin_oe
);

  // ==========================================================
  // Oscillator tick generation
  // ==========================================================
  // The tick runs at twice the oscillator rate so that bit 0 of the
  // divider toggles at the oscillator frequency itself.
  localparam [31:0] STEP = 2 * OSC_HZ;
  localparam [31:0] CLK_W = CLK_HZ;
  localparam [31:0] WRAP_AT = CLK_HZ - 2 * OSC_HZ;

  reg [31:0] phase_acc;
  reg osc_tick;
  reg [15:0] divider;
  reg sec_tick;

  // A phase accumulator keeps the long-term average exact even though
  // the system clock is not a multiple of the oscillator rate.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phase_acc <= 32'h0;
      osc_tick <= 1'b0;
    end else if (phase_acc >= WRAP_AT) begin
      phase_acc <= phase_acc + STEP - CLK_W;
      osc_tick <= 1'b1;
    end else begin
      phase_acc <= phase_acc + STEP;
      osc_tick <= 1'b0;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      divider <= 16'h0;
      sec_tick <= 1'b0;
    end else begin
      if (osc_tick) begin
        divider <= divider + 16'h0001;
      end
      sec_tick <= osc_tick & (&divider);
    end
  end

  // ==========================================================
  // Register state
  // ==========================================================
  reg minute_second_flag;
  reg watchdog_event_flag;
  reg timestamp_ground_flag;
  reg alarm_flag;
  reg countdown_flag;
  reg timestamp_irq_enable;
  reg alarm_irq_enable;
  reg countdown_irq_enable;
  reg switchover_capture_enable;
  reg battery_switchover_flag;
  reg battery_low_flag;
  reg switchover_irq_enable;
  reg battery_low_irq_enable;
  reg [1:0] temp_period_select;
  reg [2:0] output_freq_select;
  reg ts_pin_prev;

  wire [5:0] reg_index = address[7:2];
  wire bus_req = read | write;
  wire bus_take = bus_req & ~waitrequest;
  wire wr_lane = bus_take & write & byteenable[0];
  wire wr_ctrl2 = wr_lane & (reg_index == `IDX_EVENT_FLAG_ENABLE_CONTROL);
  wire wr_ctrl3 = wr_lane & (reg_index == `IDX_POWER_BATTERY_CONTROL);
  wire wr_square_wave_out_pin = wr_lane & (reg_index == `IDX_CLOCK_OUTPUT_CONTROL);
  wire [7:0] wd = writedata[7:0];
  wire ts_fall = ts_pin_prev & ~timestamp_input_pin;

  // ==========================================================
  // Avalon-MM slave handshake
  // ==========================================================
  // Every access waits exactly one cycle: waitrequest drops for one
  // cycle, and read data are loaded on the edge that drops it.
  reg [7:0] rd_byte;

  always @* begin
    rd_byte = 8'h00;
    case (reg_index)
      `IDX_EVENT_FLAG_ENABLE_CONTROL: begin
        rd_byte = {minute_second_flag, watchdog_event_flag,
          timestamp_ground_flag, alarm_flag, countdown_flag,
          timestamp_irq_enable, alarm_irq_enable, countdown_irq_enable};
      end
      `IDX_POWER_BATTERY_CONTROL: begin
        rd_byte = {power_management_select, switchover_capture_enable,
          battery_switchover_flag, battery_low_flag,
          switchover_irq_enable, battery_low_irq_enable};
      end
      `IDX_CLOCK_OUTPUT_CONTROL: begin
        rd_byte = {temp_period_select, 3'h0, output_freq_select};
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      waitrequest <= 1'b1;
      readdata <= 32'h0;
    end else if (!waitrequest) begin
      waitrequest <= 1'b1;
    end else if (bus_req) begin
      waitrequest <= 1'b0;
      readdata <= read ? {24'h0, rd_byte} : 32'h0;
    end
  end

  // ==========================================================
  // Event flags and interrupt enables
  // ==========================================================
  // A hardware event in the cycle of a clearing write wins, so no
  // event is lost. Writing 1 to a flag leaves it unchanged.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      minute_second_flag <= 1'b0;
      watchdog_event_flag <= 1'b0;
      timestamp_ground_flag <= 1'b0;
      alarm_flag <= 1'b0;
      countdown_flag <= 1'b0;
      timestamp_irq_enable <= 1'b0;
      alarm_irq_enable <= 1'b0;
      countdown_irq_enable <= 1'b0;
      ts_pin_prev <= 1'b1;
    end else begin
      ts_pin_prev <= timestamp_input_pin;
      minute_second_flag <= minute_second_event | (minute_second_flag &
        ~(wr_ctrl2 & ~wd[`BIT_MINUTE_SECOND_FLAG]));
      // Only reset clears the watchdog flag; writes have no effect on it.
      watchdog_event_flag <= watchdog_event_flag | watchdog_event;
      timestamp_ground_flag <= ts_fall | (timestamp_ground_flag &
        ~(wr_ctrl2 & ~wd[`BIT_TIMESTAMP_GROUND_FLAG]));
      alarm_flag <= alarm_event | (alarm_flag &
        ~(wr_ctrl2 & ~wd[`BIT_ALARM_FLAG]));
      countdown_flag <= countdown_event | (countdown_flag &
        ~(wr_ctrl2 & ~wd[`BIT_COUNTDOWN_FLAG]));
      if (wr_ctrl2) begin
        timestamp_irq_enable <= wd[`BIT_TIMESTAMP_IRQ_ENABLE];
        alarm_irq_enable <= wd[`BIT_ALARM_IRQ_ENABLE];
        countdown_irq_enable <= wd[`BIT_COUNTDOWN_IRQ_ENABLE];
      end
    end
  end

  // ==========================================================
  // Power and battery control
  // ==========================================================
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      power_management_select <= `RESET_POWER_MANAGEMENT_SELECT;
      switchover_capture_enable <= 1'b0;
      battery_switchover_flag <= 1'b0;
      battery_low_flag <= 1'b0;
      switchover_irq_enable <= 1'b0;
      battery_low_irq_enable <= 1'b0;
      switchover_capture <= 1'b0;
    end else begin
      if (wr_ctrl3) begin
        power_management_select <= wd[`POS_POWER_MANAGEMENT_SELECT +: 3];
        switchover_capture_enable <= wd[`BIT_SWITCHOVER_CAPTURE_ENABLE];
        switchover_irq_enable <= wd[`BIT_SWITCHOVER_IRQ_ENABLE];
        battery_low_irq_enable <= wd[`BIT_BATTERY_LOW_IRQ_ENABLE];
      end
      battery_switchover_flag <= switchover_event | (battery_switchover_flag &
        ~(wr_ctrl3 & ~wd[`BIT_BATTERY_SWITCHOVER_FLAG]));
      // Follows the detector level; writes never reach it.
      battery_low_flag <= battery_low;
      switchover_capture <= switchover_event & switchover_capture_enable;
    end
  end

  // ==========================================================
  // Interrupt output
  // ==========================================================
  // The minute/second flag has its enables elsewhere, so it is taken
  // as enabled whenever it is set. The watchdog flag cannot be cleared
  // and is kept off the line, or the line would stay stuck.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= minute_second_flag |
        (timestamp_ground_flag & timestamp_irq_enable) |
        (alarm_flag & alarm_irq_enable) |
        (countdown_flag & countdown_irq_enable) |
        (battery_switchover_flag & switchover_irq_enable) |
        (battery_low_flag & battery_low_irq_enable);
    end
  end

  // ==========================================================
  // Clock output control register
  // ==========================================================
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      temp_period_select <= `RESET_TEMP_PERIOD_SELECT;
      output_freq_select <= `RESET_OUTPUT_FREQ_SELECT;
    end else if (wr_square_wave_out_pin) begin
      temp_period_select <= wd[`POS_TEMP_PERIOD_SELECT +: 2];
      output_freq_select <= wd[`POS_OUTPUT_FREQ_SELECT +: 3];
    end
  end

  // ==========================================================
  // Temperature measurement timing
  // ==========================================================
  reg [7:0] period_sec;
  reg [7:0] sec_count;
  reg start_pending;

  always @* begin
    case (temp_period_select)
      2'h0: period_sec = `TEMP_PERIOD_4_MIN_SEC;
      2'h1: period_sec = `TEMP_PERIOD_2_MIN_SEC;
      2'h2: period_sec = `TEMP_PERIOD_1_MIN_SEC;
      2'h3: period_sec = `TEMP_PERIOD_30_SEC;
      default: period_sec = `TEMP_PERIOD_4_MIN_SEC;
    endcase
  end

  // The greater-or-equal compare lets a shorter period take effect at
  // once instead of waiting for the counter to wrap.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sec_count <= 8'h0;
      start_pending <= 1'b1;
      temp_measure_start <= 1'b0;
    end else begin
      start_pending <= 1'b0;
      temp_measure_start <= start_pending;
      if (sec_tick) begin
        if (sec_count >= period_sec - 8'h01) begin
          sec_count <= 8'h0;
          temp_measure_start <= 1'b1;
        end else begin
          sec_count <= sec_count + 8'h01;
        end
      end
    end
  end

  // ==========================================================
  // Square-wave output
  // ==========================================================
  // Every divider bit toggles on a tick edge, so all divided rates are
  // 50:50. The top rate inherits the tick's jitter, which is why it is
  // a poor reference for frequency measurements.
  reg wave;

  always @* begin
    case (output_freq_select)
      3'h0: wave = divider[0];
      3'h1: wave = divider[1];
      3'h2: wave = divider[2];
      3'h3: wave = divider[3];
      3'h4: wave = divider[4];
      3'h5: wave = divider[5];
      `FREQ_SELECT_ONE_HZ: wave = divider[15];
      default: wave = 1'b1;
    endcase
  end

  // Open drain: the pin only ever pulls low; a high level and the
  // disabled state both release it.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      square_wave_out_pin <= 1'b0;
      square_wave_out_pin_oe <= 1'b0;
    end else begin
      square_wave_out_pin <= 1'b0;
      square_wave_out_pin_oe <= (output_freq_select != `FREQ_SELECT_DISABLED) & ~wave;
    end
  end

endmodule
`default_nettype wire

// *** test/rtc_ctrl_properties.sv ***
// Concurrent port checks for the RTC status and clock output block.
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Port checker
module rtc_ctrl_properties (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic minute_second_event,
  input wire logic switchover_event,
  input wire logic irq,
  input wire logic switchover_capture,
  input wire logic [2:0] power_management_select,
  input wire logic temp_measure_start,
  input wire logic square_wave_out_pin
);
  // A write to the power register is the only thing allowed to move the selector.
  wire pm_wr = write && !waitrequest && address[7:2] == 6'h02;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  AST_ONE_WAIT: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_ACCEPT: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered after one wait cycle");
  AST_REPLY_CAUSE: assert property ($fell(waitrequest) |-> $past(read || write))
    else $error("answer without a request");
  AST_READ_UPPER: assert property (!waitrequest |-> readdata[31:8] == 24'h0)
    else $error("upper read data lanes not zero");
  AST_OD_DATA: assert property (square_wave_out_pin == 1'b0)
    else $error("open-drain data driven high");
  AST_MSF_IRQ: assert property (minute_second_event |-> ##2 irq)
    else $error("tick event did not raise the interrupt");
  AST_CAPTURE_CAUSE: assert property (switchover_capture |-> $past(switchover_event))
    else $error("capture without a switch-over");
  AST_PM_WRITE: assert property ($changed(power_management_select) |->
    $past(pm_wr) || $past(pm_wr, 2))
    else $error("power selector changed without a write");
  AST_TEMP_PULSE: assert property (temp_measure_start |=> !temp_measure_start)
    else $error("measurement start longer than one cycle");
endmodule
bind rtc_status_and_clock_output_ctrl rtc_ctrl_properties u_props (
  .clk(clk), .arst_n(arst_n), .address(address), .read(read), .write(write),
  .readdata(readdata), .waitrequest(waitrequest), .minute_second_event(minute_second_event),
  .switchover_event(switchover_event), .irq(irq), .switchover_capture(switchover_capture),
  .power_management_select(power_management_select), .temp_measure_start(temp_measure_start),
  .square_wave_out_pin(square_wave_out_pin));
`default_nettype wire

// *** test/tb_rtc_status_and_clock_output_ctrl.sv ***
// Register-level testbench of the RTC status and clock output block.
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Bench
module tb_rtc_status_and_clock_output_ctrl;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [3:0] byteenable = 4'h0;
  logic [31:0] writedata = 32'h0;
  logic [5:0] ev = 6'h00;
  logic battery_low = 1'b0;
  wire [31:0] readdata;
  wire waitrequest, irq, switchover_capture, temp_measure_start, sq_pin, sq_oe;
  wire [2:0] power_management_select;
  int fail_count = 0;
  int comparisons = 0;
  int temp_pulses = 0;
  int cap_pulses = 0;
  int n;
  logic [31:0] q;
  always #10 clk = ~clk;
  always @(posedge clk) begin
    if (temp_measure_start === 1'b1) temp_pulses++;
    if (switchover_capture === 1'b1) cap_pulses++;
  end
  // Event lines: 0 countdown, 1 alarm, 2 timestamp (pin pulled low), 3 tick, 4 watchdog, 5 switch-over.
  rtc_status_and_clock_output_ctrl #(.CLK_HZ(131072), .OSC_HZ(32768)) DUT (
    .clk(clk), .arst_n(arst_n), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .minute_second_event(ev[3]), .watchdog_event(ev[4]),
    .timestamp_input_pin(~ev[2]), .alarm_event(ev[1]), .countdown_event(ev[0]),
    .switchover_event(ev[5]), .battery_low(battery_low), .irq(irq),
    .switchover_capture(switchover_capture), .power_management_select(power_management_select),
    .temp_measure_start(temp_measure_start), .square_wave_out_pin(sq_pin),
    .square_wave_out_pin_oe(sq_oe));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // The request is held until waitrequest is sampled low; a spare edge follows the release.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                      input logic [3:0] be);
    int k;
    k = 0;
    address <= a;
    writedata <= {24'h0, d};
    byteenable <= be;
    write <= wr;
    read <= ~wr;
    @(posedge clk);
    while (waitrequest !== 1'b0) begin
      k++;
      if (k > 20) begin
        fail_count++;
        summarize();
      end
      @(posedge clk);
    end
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d, 4'h1);
  endtask
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 8'h00, 4'h1);
    check(name, q, exp);
  endtask
  task automatic irq_is(input logic e);
    repeat (2) @(posedge clk);
    check("irq", {31'h0, irq}, {31'h0, e});
  endtask
  task automatic pulse(input int k);
    ev[k] <= 1'b1;
    @(posedge clk);
    ev[k] <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic measure(input int len, output int hi);
    hi = 0;
    repeat (len) begin
      @(posedge clk);
      if (sq_oe === 1'b1) hi++;
    end
  endtask
  initial begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd_chk("event reg reset", 8'h04, 32'h0);
    rd_chk("power reg reset", 8'h08, 32'h0);
    rd_chk("square_wave_out_pin reg reset", 8'h3c, 32'h0);
    rd_chk("unmapped read", 8'h00, 32'h0);
    check("start pulses", temp_pulses, 1);
    measure(16, n);
    check("output runs at reset", {31'h0, n > 0 && n < 16}, 32'h1);
    $display("test reset done");
    wr(8'h3c, 8'hff);
    rd_chk("square_wave_out_pin unused bits", 8'h3c, 32'hc7);
    measure(64, n);
    check("output disabled", n, 0);
    xfer(1'b1, 8'h3c, 8'h00, 4'h0);
    rd_chk("lane0 off write", 8'h3c, 32'hc7);
    wr(8'h40, 8'h5a);
    rd_chk("unmapped write", 8'h40, 32'h0);
    wr(8'h08, 8'hff);
    rd_chk("power reg", 8'h08, 32'hf3);
    check("pm select", {29'h0, power_management_select}, 32'h7);
    $display("test registers done");
    for (int i = 0; i < 3; i++) begin
      wr(8'h04, 8'h07 ^ (8'h01 << i));
      pulse(i);
      rd_chk("flag set", 8'h04, (32'h07 ^ (32'h1 << i)) | (32'h8 << i));
      irq_is(1'b0);
      wr(8'h04, 8'hff);
      irq_is(1'b1);
      wr(8'h04, 8'h07);
      rd_chk("flag cleared", 8'h04, 32'h07);
      irq_is(1'b0);
    end
    pulse(3);
    irq_is(1'b1);
    pulse(4);
    wr(8'h04, 8'h07);
    rd_chk("watchdog kept", 8'h04, 32'h47);
    irq_is(1'b0);
    $display("test event flags done");
    pulse(5);
    battery_low <= 1'b1;
    repeat (2) @(posedge clk);
    rd_chk("switchover and low", 8'h08, 32'hff);
    check("capture pulses", cap_pulses, 1);
    wr(8'h08, 8'hf3);
    rd_chk("low not clearable", 8'h08, 32'hf7);
    irq_is(1'b1);
    wr(8'h08, 8'h02);
    irq_is(1'b0);
    battery_low <= 1'b0;
    pulse(5);
    rd_chk("switchover no capture", 8'h08, 32'h0a);
    check("capture pulses", cap_pulses, 1);
    irq_is(1'b1);
    wr(8'h08, 8'h08);
    irq_is(1'b0);
    $display("test battery done");
    // Windows span whole periods of 4 << c cycles, so the count does not depend on phase.
    for (int c = 1; c < 6; c++) begin
      wr(8'h3c, 8'(c));
      repeat (8) @(posedge clk);
      measure(16 << c, n);
      check("duty", n, 8 << c);
    end
    // The run stays inside the first half second, so the 1 Hz wave is still low.
    wr(8'h3c, 8'h06);
    repeat (8) @(posedge clk);
    measure(64, n);
    check("one hz low half", n, 64);
    $display("test clock output done");
    summarize();
  end
endmodule
`default_nettype wire
